// File: common/sses_pkg.sv
// Purpose: shared constants and types for the sleep/subtract/swap execution block
// Assumes: 8-bit data path, 12-bit instruction words, 32 file registers
// Notes:   register offsets are byte addresses on a 32-bit APB bus
package sses_pkg;

    // apb register map
    localparam logic [7:0] SSES_OFS_INSTR  = 8'h00;
    localparam logic [7:0] SSES_OFS_WORK   = 8'h04;
    localparam logic [7:0] SSES_OFS_STATUS = 8'h08;
    localparam logic [7:0] SSES_OFS_WDOG   = 8'h0C;
    localparam logic [7:0] SSES_OFS_FILE   = 8'h80;
    localparam logic [4:0] SSES_LAST_CTRL  = 5'h03;

    // status register bit positions
    localparam int unsigned SSES_ST_C           = 0;
    localparam int unsigned SSES_ST_DIGIT_CARRY = 1;
    localparam int unsigned SSES_ST_Z           = 2;
    localparam int unsigned SSES_ST_POWERDOWN   = 3;
    localparam int unsigned SSES_ST_TIMEOUT     = 4;
    localparam int unsigned SSES_ST_SLEEP       = 5;
    localparam int unsigned SSES_ST_WAKE        = 6;

    // watchdog register field positions
    localparam int unsigned SSES_WD_CNT_LSB = 0;
    localparam int unsigned SSES_WD_PRE_LSB = 8;

    // values after reset
    localparam logic [7:0]  SSES_RST_WORK = 8'h00;
    localparam logic [7:0]  SSES_RST_FILE = 8'h00;
    localparam logic [7:0]  SSES_RST_WDOG      = 8'h00;
    localparam logic [7:0]  SSES_RST_PRE       = 8'h00;
    localparam logic        SSES_RST_POWERDOWN = 1'b1;
    localparam logic        SSES_RST_TIMEOUT   = 1'b1;
    localparam logic [11:0] SSES_RST_OP   = 12'h000;

    // opcodes
    localparam logic [11:0] SSES_OP_SLEEP = 12'h003;
    localparam logic [5:0]  SSES_OP_SUB   = 6'h02;
    localparam logic [5:0]  SSES_OP_SWAP  = 6'h0E;
    localparam logic [7:0]  SSES_WDOG_CLR = 8'h00;
    localparam logic [7:0]  SSES_PRE_TOP  = 8'hFF;

    typedef enum logic [1:0] {
        SSES_K_NONE  = 2'b00,
        SSES_K_SLEEP = 2'b01,
        SSES_K_SUB   = 2'b10,
        SSES_K_SWAP  = 2'b11
    } sses_kind_type;

    typedef enum logic {
        SSES_RUN   = 1'b0,
        SSES_SLEEP = 1'b1
    } sses_mode_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sses_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sses_apb_rsp_type;

    typedef struct packed {
        logic c;
        logic digit_carry_flag;
        logic z;
    } sses_flags_type;

    function automatic sses_kind_type sses_decode(input logic [11:0] op);
        sses_kind_type k;
        k = SSES_K_NONE;
        if (op == SSES_OP_SLEEP) begin
            k = SSES_K_SLEEP;
        end else if (op[11:6] == SSES_OP_SUB) begin
            k = SSES_K_SUB;
        end else if (op[11:6] == SSES_OP_SWAP) begin
            k = SSES_K_SWAP;
        end
        return k;
    endfunction

endpackage

// File: hw/sses_alu.sv
// Purpose: datapath for subtract and nibble swap
// Assumes: purely combinational, evaluated in the executing cycle
// Notes:   flags are only meaningful for the subtract kind
`timescale 1ns/1ps
module sses_alu
    import sses_pkg::*;
(
    input  wire sses_kind_type  kind,
    input  wire logic [7:0]     file_val,
    input  wire logic [7:0]     work_val,
    output logic [7:0]          result,
    output sses_flags_type      flags
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // two's complement: f + ~w + 1, carry out means no borrow
    assign full_sum = {1'b0, file_val} + {1'b0, ~work_val} + 9'h001;
    assign low_sum  = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + 5'h01;

    always_comb begin
        result   = file_val;
        flags.c                = full_sum[8];
        flags.digit_carry_flag = low_sum[4];
        flags.z                = (full_sum[7:0] == 8'h00);
        unique case (kind)
            SSES_K_SUB: begin
                result = full_sum[7:0];
            end
            SSES_K_SWAP: begin
                result = {file_val[3:0], file_val[7:4]};
            end
            SSES_K_SLEEP, SSES_K_NONE: begin
                result = file_val;
            end
        endcase
    end
endmodule

// File: hw/sses_exec.sv
// Purpose: execute the low-power entry, subtract and nibble-swap instructions
// Assumes: apb master on the same clock; instructions arrive as writes to the instr register
// Notes:   working, status, file and watchdog state live here and are visible over apb
//
// Overview of operation
// - Executing the low-power opcode 0x003 sets the time-out flag.
// - The low-power instruction clears the power-down flag.
// - The low-power instruction zeroes the watchdog counter and its prescaler.
// - After the low-power instruction the core halts and executes nothing until a status write sets the wake bit.
// - Subtract computes file register minus working register in two's complement.
// - Subtract with d=0 writes the working register, with d=1 the file register.
// - A subtract without borrow sets the carry flag.
// - A subtract with borrow clears carry and keeps the wrapped 8-bit difference.
// - Nibble swap exchanges the upper and lower nibbles of the file register.
// - Nibble swap with d=0 writes the working register, with d=1 the file register.
`timescale 1ns/1ps
module sses_exec
    import sses_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire sses_apb_req_type apb_req,
    output sses_apb_rsp_type      apb_rsp,
    output logic                  sleep_o,
    output logic                  retire_o
);

    typedef struct packed {
        sses_apb_rsp_type rsp;
        sses_mode_type    mode;
        logic             retire;
        logic [11:0]      last_op;
        logic [7:0]       work;
        logic             c;
        logic             digit_carry_flag;
        logic             z;
        logic             powerdown_flag;
        logic             timeout_flag;
        logic [7:0]       watchdog_counter;
        logic [7:0]       pre;
        logic [31:0][7:0] files;
    } sses_state_type;

    sses_state_type s_reg;
    sses_state_type s_next;

    logic           acc_wr;
    logic           rd_phase;
    logic           addr_hit;
    logic           exec_now;
    sses_kind_type  kind_now;
    logic [4:0]     fidx_now;
    logic           dest_now;
    logic [7:0]     fval_now;
    logic [7:0]     alu_res;
    sses_flags_type alu_flags;
    logic [31:0]    rd_data;

    // a wait state is inserted so the response fields leave flip-flops
    assign rd_phase = apb_req.psel & apb_req.penable & ~s_reg.rsp.pready;
    assign acc_wr   = apb_req.psel & apb_req.penable & s_reg.rsp.pready & apb_req.pwrite;
    assign addr_hit = (apb_req.paddr[1:0] == 2'b00)
                    & (apb_req.paddr[7] | (apb_req.paddr[6:2] <= SSES_LAST_CTRL));

    assign kind_now = sses_decode(apb_req.pwdata[11:0]);
    assign fidx_now = apb_req.pwdata[4:0];
    assign dest_now = apb_req.pwdata[5];
    assign fval_now = s_reg.files[fidx_now];
    // a halted core takes no instruction
    assign exec_now = acc_wr & (apb_req.paddr == SSES_OFS_INSTR)
                    & (s_reg.mode == SSES_RUN);

    sses_alu u_alu (
        .kind     (kind_now),
        .file_val (fval_now),
        .work_val (s_reg.work),
        .result   (alu_res),
        .flags    (alu_flags)
    );

    always_comb begin
        rd_data = 32'h0000_0000;
        if (apb_req.paddr[7]) begin
            rd_data[7:0] = s_reg.files[apb_req.paddr[6:2]];
        end else begin
            unique case (apb_req.paddr)
                SSES_OFS_INSTR: begin
                    rd_data[11:0] = s_reg.last_op;
                end
                SSES_OFS_WORK: begin
                    rd_data[7:0] = s_reg.work;
                end
                SSES_OFS_STATUS: begin
                    rd_data[SSES_ST_C]           = s_reg.c;
                    rd_data[SSES_ST_DIGIT_CARRY] = s_reg.digit_carry_flag;
                    rd_data[SSES_ST_Z]           = s_reg.z;
                    rd_data[SSES_ST_POWERDOWN]   = s_reg.powerdown_flag;
                    rd_data[SSES_ST_TIMEOUT]     = s_reg.timeout_flag;
                    rd_data[SSES_ST_SLEEP]       = (s_reg.mode == SSES_SLEEP);
                end
                SSES_OFS_WDOG: begin
                    rd_data[SSES_WD_CNT_LSB +: 8] = s_reg.watchdog_counter;
                    rd_data[SSES_WD_PRE_LSB +: 8] = s_reg.pre;
                end
                default: begin
                    rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    always_comb begin
        s_next             = s_reg;
        s_next.retire      = 1'b0;
        s_next.rsp.pready  = 1'b0;
        s_next.rsp.pslverr = 1'b0;

        // watchdog runs only while the oscillator does
        unique case (s_reg.mode)
            SSES_RUN: begin
                s_next.pre = s_reg.pre + 8'h01;
                if (s_reg.pre == SSES_PRE_TOP) begin
                    s_next.watchdog_counter = s_reg.watchdog_counter + 8'h01;
                end
            end
            SSES_SLEEP: begin
                s_next.pre = s_reg.pre;
            end
        endcase

        if (rd_phase) begin
            s_next.rsp.pready  = 1'b1;
            s_next.rsp.pslverr = ~addr_hit;
            s_next.rsp.prdata  = addr_hit ? rd_data : 32'h0000_0000;
        end

        if (acc_wr && addr_hit) begin
            if (apb_req.paddr[7]) begin
                s_next.files[apb_req.paddr[6:2]] = apb_req.pwdata[7:0];
            end else if (apb_req.paddr == SSES_OFS_WORK) begin
                s_next.work = apb_req.pwdata[7:0];
            end else if (apb_req.paddr == SSES_OFS_STATUS) begin
                s_next.c                = apb_req.pwdata[SSES_ST_C];
                s_next.digit_carry_flag = apb_req.pwdata[SSES_ST_DIGIT_CARRY];
                s_next.z                = apb_req.pwdata[SSES_ST_Z];
                s_next.powerdown_flag   = apb_req.pwdata[SSES_ST_POWERDOWN];
                s_next.timeout_flag     = apb_req.pwdata[SSES_ST_TIMEOUT];
                if (apb_req.pwdata[SSES_ST_WAKE]) begin
                    s_next.mode = SSES_RUN;
                end
            end
        end

        if (exec_now) begin
            s_next.last_op = apb_req.pwdata[11:0];
            s_next.retire  = (kind_now != SSES_K_NONE);
            unique case (kind_now)
                SSES_K_SLEEP: begin
                    s_next.timeout_flag     = 1'b1;
                    s_next.powerdown_flag   = 1'b0;
                    s_next.watchdog_counter = SSES_WDOG_CLR;
                    s_next.pre              = SSES_RST_PRE;
                    s_next.mode             = SSES_SLEEP;
                end
                SSES_K_SUB: begin
                    // result wraps to 8 bits on borrow
                    if (dest_now) begin
                        s_next.files[fidx_now] = alu_res;
                    end else begin
                        s_next.work = alu_res;
                    end
                    s_next.c                = alu_flags.c;
                    s_next.digit_carry_flag = alu_flags.digit_carry_flag;
                    s_next.z                = alu_flags.z;
                end
                SSES_K_SWAP: begin
                    // flags deliberately untouched
                    if (dest_now) begin
                        s_next.files[fidx_now] = alu_res;
                    end else begin
                        s_next.work = alu_res;
                    end
                end
                SSES_K_NONE: begin
                    s_next.retire = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg.rsp     <= '0;
            s_reg.mode    <= SSES_RUN;
            s_reg.retire  <= 1'b0;
            s_reg.last_op <= SSES_RST_OP;
            s_reg.work    <= SSES_RST_WORK;
            s_reg.c       <= 1'b0;
            s_reg.digit_carry_flag <= 1'b0;
            s_reg.z                <= 1'b0;
            s_reg.powerdown_flag   <= SSES_RST_POWERDOWN;
            s_reg.timeout_flag     <= SSES_RST_TIMEOUT;
            s_reg.watchdog_counter <= SSES_RST_WDOG;
            s_reg.pre     <= SSES_RST_PRE;
            s_reg.files   <= {32{SSES_RST_FILE}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign apb_rsp  = s_reg.rsp;
    assign sleep_o  = s_reg.mode;
    assign retire_o = s_reg.retire;

    // checks, independent of the alu
    logic [7:0] chk_diff;
    logic       chk_nob;
    logic       chk_dnb;
    logic [7:0] chk_swap;
    logic       halted_instr;

    assign chk_diff     = fval_now - s_reg.work;
    assign chk_nob      = (fval_now >= s_reg.work);
    assign chk_dnb      = (fval_now[3:0] >= s_reg.work[3:0]);
    assign chk_swap     = {fval_now[3:0], fval_now[7:4]};
    assign halted_instr = acc_wr & (apb_req.paddr == SSES_OFS_INSTR)
                        & (s_reg.mode == SSES_SLEEP);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_sleep_issue;
        exec_now && (kind_now == SSES_K_SLEEP);
    endsequence

    sequence s_sub_issue;
        exec_now && (kind_now == SSES_K_SUB);
    endsequence

    sequence s_swap_issue;
        exec_now && (kind_now == SSES_K_SWAP);
    endsequence

    sequence s_halted;
        sleep_o && (s_reg.pre == SSES_RST_PRE);
    endsequence

    property p_sleep_to;
        s_sleep_issue |=> s_reg.timeout_flag;
    endproperty
    a_sleep_to: assert property (p_sleep_to)
        else $error("time-out flag not set by low-power entry");

    property p_sleep_pd;
        s_sleep_issue |=> !s_reg.powerdown_flag && s_reg.timeout_flag;
    endproperty
    a_sleep_pd: assert property (p_sleep_pd)
        else $error("power-down flag not cleared by low-power entry");

    property p_sleep_wdt;
        s_sleep_issue |=> s_reg.watchdog_counter == SSES_WDOG_CLR && s_reg.pre == SSES_RST_PRE;
    endproperty
    a_sleep_wdt: assert property (p_sleep_wdt)
        else $error("watchdog or prescaler not cleared on low-power entry");

    property p_sleep_halt;
        s_sleep_issue |=> s_halted ##1 s_halted;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt)
        else $error("core still running after low-power entry");

    property p_no_exec_asleep;
        halted_instr |=> $stable(s_reg.work) && $stable(s_reg.files) && !retire_o;
    endproperty
    a_no_exec_asleep: assert property (p_no_exec_asleep)
        else $error("instruction executed while halted");

    property p_sub_to_work;
        s_sub_issue and !dest_now |=> s_reg.work == $past(chk_diff);
    endproperty
    a_sub_to_work: assert property (p_sub_to_work)
        else $error("subtract result wrong in working register");

    property p_sub_to_file;
        s_sub_issue and dest_now
            |=> (s_reg.files[$past(fidx_now)] == $past(chk_diff)) && $stable(s_reg.work);
    endproperty
    a_sub_to_file: assert property (p_sub_to_file)
        else $error("subtract result wrong in file register");

    property p_sub_carry;
        s_sub_issue |=> s_reg.c == $past(chk_nob);
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("carry does not reflect borrow");

    property p_sub_borrow;
        s_sub_issue and !chk_nob and !dest_now |=> !s_reg.c && (s_reg.work == $past(chk_diff));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("borrowing subtract mishandled");

    property p_sub_flags;
        s_sub_issue |=> (s_reg.digit_carry_flag == $past(chk_dnb))
            && (s_reg.z == ($past(chk_diff) == 8'h00));
    endproperty
    a_sub_flags: assert property (p_sub_flags)
        else $error("digit-carry or zero wrong after subtract");

    property p_swap_value;
        s_swap_issue and !dest_now |=> s_reg.work == $past(chk_swap);
    endproperty
    a_swap_value: assert property (p_swap_value)
        else $error("nibble swap result wrong");

    property p_swap_file;
        s_swap_issue and dest_now
            |=> (s_reg.files[$past(fidx_now)] == $past(chk_swap)) && $stable(s_reg.work);
    endproperty
    a_swap_file: assert property (p_swap_file)
        else $error("nibble swap not written to file register");

    property p_swap_flags;
        s_swap_issue |=> $stable({s_reg.c, s_reg.digit_carry_flag, s_reg.z,
                                  s_reg.powerdown_flag, s_reg.timeout_flag});
    endproperty
    a_swap_flags: assert property (p_swap_flags)
        else $error("nibble swap changed a flag");

    property p_one_cycle;
        exec_now && (kind_now != SSES_K_NONE) |=> retire_o ##1 !retire_o;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("instruction did not retire in one cycle");

endmodule

// File: tb/sses_fetch_model.sv
// Purpose: fetch side model, issues apb transfers into the execution block
// Assumes: one clock, slave answers with pready after a wait state of its own choosing
// Notes:   idle cycle between transfers; request held until pready is sampled high
`timescale 1ns/1ps
module sses_fetch_model
    import sses_pkg::*;
(
    input  wire logic            mclk,
    output sses_apb_req_type     apb_req,
    input  wire sses_apb_rsp_type apb_rsp
);
    initial begin
        apb_req = '0;
    end

    // values are read just after the edge, before that edge's updates land
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge mclk);
        apb_req.psel    <= 1'b1;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err   = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the subtract, nibble swap and low-power execution
// Assumes: instructions are issued as apb writes to the instr register
// Notes:   expected flags are worked out here from plain arithmetic
`timescale 1ns/1ps
module tb
    import sses_pkg::*;
;

    logic             mclk;
    logic             rst;
    sses_apb_req_type apb_req;
    sses_apb_rsp_type apb_rsp;
    logic             sleep_o;
    logic             retire_o;
    int               n_mismatch;
    int               n_checks;
    int               n_retire;
    logic [31:0]      rd;
    logic             err;
    logic [7:0]       fv [3] = '{8'h03, 8'h01, 8'h02};
    logic [4:0]       fa [3] = '{5'd3, 5'd4, 5'd31};
    logic             dv [3] = '{1'b1, 1'b0, 1'b1};
    logic [7:0]       diff;
    logic [7:0]       st;

    sses_exec i_sses_exec (
        .mclk     (mclk),
        .rst      (rst),
        .apb_req  (apb_req),
        .apb_rsp  (apb_rsp),
        .sleep_o  (sleep_o),
        .retire_o (retire_o)
    );

    sses_fetch_model i_sses_fetch_model (
        .mclk    (mclk),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (retire_o === 1'b1) begin
            n_retire++;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        i_sses_fetch_model.xfer(1'b1, addr, data, rd, err);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        i_sses_fetch_model.xfer(1'b0, addr, 32'h0000_0000, rd, err);
        check(name, rd, exp);
    endtask

    function automatic logic [7:0] fadr(input logic [4:0] f);
        return SSES_OFS_FILE + {1'b0, f, 2'b00};
    endfunction

    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        n_mismatch = 0;
        n_checks = 0;
        n_retire = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_chk("work after reset", SSES_OFS_WORK, 32'h0000_0000);
        rd_chk("status after reset", SSES_OFS_STATUS, 32'h0000_0018);
        // subtract: no borrow into file, borrow into work, zero result into file
        for (int i = 0; i < 3; i++) begin
            wr(fadr(fa[i]), {24'h0, fv[i]});
            wr(SSES_OFS_WORK, 32'h0000_0002);
            wr(SSES_OFS_STATUS, 32'h0000_0018);
            wr(SSES_OFS_INSTR, {20'h0, SSES_OP_SUB, dv[i], fa[i]});
            diff = fv[i] - 8'h02;
            st = {3'b000, 2'b11, diff == 8'h00, fv[i][3:0] >= 4'h2, fv[i] >= 8'h02};
            rd_chk("sub file", fadr(fa[i]), {24'h0, dv[i] ? diff : fv[i]});
            rd_chk("sub work", SSES_OFS_WORK, {24'h0, dv[i] ? 8'h02 : diff});
            rd_chk("sub flags", SSES_OFS_STATUS, {24'h0, st});
        end
        // nibble swap with every flag set, first to work then back to the file
        wr(fadr(5'd7), 32'h0000_00A5);
        wr(SSES_OFS_WORK, 32'h0000_0033);
        wr(SSES_OFS_STATUS, 32'h0000_001F);
        wr(SSES_OFS_INSTR, {20'h0, SSES_OP_SWAP, 1'b0, 5'd7});
        rd_chk("swap work", SSES_OFS_WORK, 32'h0000_005A);
        rd_chk("swap file kept", fadr(5'd7), 32'h0000_00A5);
        wr(SSES_OFS_INSTR, {20'h0, SSES_OP_SWAP, 1'b1, 5'd7});
        rd_chk("swap file", fadr(5'd7), 32'h0000_005A);
        rd_chk("swap work kept", SSES_OFS_WORK, 32'h0000_005A);
        rd_chk("swap flags", SSES_OFS_STATUS, 32'h0000_001F);
        // unmapped address is refused
        i_sses_fetch_model.xfer(1'b0, 8'h10, 32'h0000_0000, rd, err);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        // low-power entry from a cleared time-out flag, watchdog has been counting
        // wait long enough for the prescaler to wrap so the counter clear is visible
        repeat (300) @(posedge mclk);
        wr(SSES_OFS_STATUS, 32'h0000_0008);
        wr(SSES_OFS_INSTR, {20'h0, SSES_OP_SLEEP});
        @(negedge mclk);
        check("sleep output", {31'h0, sleep_o}, 32'h0000_0001);
        rd_chk("sleep status", SSES_OFS_STATUS, 32'h0000_0030);
        rd_chk("sleep watchdog", SSES_OFS_WDOG, 32'h0000_0000);
        // a halted core executes nothing
        wr(SSES_OFS_INSTR, {20'h0, SSES_OP_SWAP, 1'b0, 5'd7});
        rd_chk("halted work", SSES_OFS_WORK, 32'h0000_005A);
        // leave the halt, then issue a code that is none of the three
        wr(SSES_OFS_STATUS, 32'h0000_0040);
        @(negedge mclk);
        check("woken", {31'h0, sleep_o}, 32'h0000_0000);
        wr(SSES_OFS_INSTR, 32'h0000_0FF0);
        rd_chk("other opcode", SSES_OFS_INSTR, 32'h0000_0FF0);
        rd_chk("other opcode work", SSES_OFS_WORK, 32'h0000_005A);
        check("retired count", n_retire, 32'd6);
        conclude();
    end
endmodule
